// file: core/ssr_pkg.sv
package ssr_pkg;
    // status byte bit positions
    localparam int unsigned POS_MEAS = 0;
    localparam int unsigned POS_UNUSED = 1;
    localparam int unsigned POS_EAV = 2;
    localparam int unsigned POS_QUES = 3;
    localparam int unsigned POS_MAV = 4;
    localparam int unsigned POS_STD = 5;
    localparam int unsigned POS_RQS = 6;
    localparam int unsigned POS_OPER = 7;
    // reset values and summary position mask
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] SUMMARY_BITS = 8'hbd;
    localparam logic [7:0] STD_RESET = 8'h00;
    // decimal answer width (0..32768 fits 16 bits)
    localparam int unsigned REG_W = 16;
    // query selector codes
    typedef enum logic [1:0] {
        SSR_Q_NONE = 2'b00,
        SSR_Q_STB = 2'b01,
        SSR_Q_MASK = 2'b10,
        SSR_Q_STD = 2'b11
    } ssr_query_t;
endpackage

// file: core/ssr_event_set.sv
`timescale 1ns/1ps
module ssr_event_set
    import ssr_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // events and control
    input wire logic [W-1:0] event_in,
    input wire logic [W-1:0] enable_in,
    input wire logic clear,
    // state
    output logic [W-1:0] event_q,
    output logic summary
);
    logic [W-1:0] event_d;

    // sticky bits; an event in the clearing cycle survives
    assign event_d = (clear ? '0 : event_q) | event_in;
    assign summary = |(event_q & enable_in);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_q <= '0;
        end else if (clk_en) begin
            event_q <= event_d;
        end
    end
endmodule

// file: core/ssr_status_byte.sv
`timescale 1ns/1ps
// Function
// - enabled set summaries at B0,B3,B5,B7
// - B2 high while error queue nonempty
// - B4 high while output queue nonempty
// - summary bits follow sources, never stored
// - reading standard event register clears it
// - master summary ORs masked summary bits
// - 8-bit mask, writable 0..255, readable
// - mask clears at power-up, write zero
// - clear-status and preset leave mask alone
// - enabled rising bit sets request, asserts line
// - B6 request on poll, master on query
// - completed serial poll clears request flag
// - same event may request again later
// - poll never clears master summary
// - queries return binary weighted value
// - event bits sticky, summary is masked OR
// - power-up clears registers, queues empty
module ssr_status_byte
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // summaries from other event sets
    input wire logic meas_summary,
    input wire logic questionable_summary,
    input wire logic operation_summary,
    // queue state
    input wire logic error_available,
    input wire logic message_available,
    // standard event set sources
    input wire logic [7:0] std_event_in,
    input wire logic [7:0] std_enable,
    // commands
    input wire logic mask_write,
    input wire logic [7:0] mask_wdata,
    input wire logic query_req,
    input wire logic [1:0] query_sel,
    input wire logic clear_status,
    input wire logic status_preset,
    // serial poll (controller side sequence)
    input wire logic serial_poll_done,
    // answers
    output logic [REG_W-1:0] query_data_q,
    output logic query_valid_q,
    output logic [7:0] poll_byte_q,
    output logic [7:0] status_summary_byte_q,
    output logic service_request_q
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // standard event set
    // ------------------------------------------------------------
    logic [7:0] std_event_q;
    logic std_summary;
    logic std_clear;
    logic std_read;

    // a read of the standard register or a clear-status empties it
    assign std_read = query_req && (ssr_query_t'(query_sel) == SSR_Q_STD);
    assign std_clear = std_read | clear_status;

    ssr_event_set #(
        .W(8)
    ) u_std (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .clk_en(clk_en),
        .event_in(std_event_in),
        .enable_in(std_enable),
        .clear(std_clear),
        .event_q(std_event_q),
        .summary(std_summary)
    );

    // ------------------------------------------------------------
    // status byte assembly, purely combinational
    // ------------------------------------------------------------
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] summary_bits;
    logic [7:0] enabled_bits;
    logic master_summary;

    assign summary_bits[POS_MEAS] = meas_summary;
    assign summary_bits[POS_UNUSED] = 1'b0;
    assign summary_bits[POS_EAV] = error_available;
    assign summary_bits[POS_QUES] = questionable_summary;
    assign summary_bits[POS_MAV] = message_available;
    assign summary_bits[POS_STD] = std_summary;
    assign summary_bits[POS_RQS] = 1'b0;
    assign summary_bits[POS_OPER] = operation_summary;

    // unused and B6 positions masked out so they never contribute
    assign enabled_bits = summary_bits & mask_q & SUMMARY_BITS;
    assign master_summary = |enabled_bits;

    // ------------------------------------------------------------
    // request edge detect and flag
    // ------------------------------------------------------------
    logic [7:0] enabled_prev_q;
    logic new_request;
    logic rqs_q;
    logic rqs_d;

    // per-bit rise so a re-armed event can request again after poll
    assign new_request = |(enabled_bits & ~enabled_prev_q);
    // set wins over poll clear in the same cycle
    assign rqs_d = new_request | (rqs_q & ~serial_poll_done);

    // ------------------------------------------------------------
    // mask register; clear-status and preset deliberately unused
    // ------------------------------------------------------------
    assign mask_d = mask_write ? mask_wdata : mask_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= MASK_RESET;
            enabled_prev_q <= 8'h00;
            rqs_q <= 1'b0;
        end else if (clk_en) begin
            mask_q <= mask_d;
            enabled_prev_q <= enabled_bits;
            rqs_q <= rqs_d;
        end
    end

    // ------------------------------------------------------------
    // query answers, binary weighted (bit n weighs 2^n)
    // ------------------------------------------------------------
    logic [7:0] stb_query;
    logic [7:0] stb_poll;
    logic [REG_W-1:0] query_mux;

    assign stb_query = summary_bits | {1'b0, master_summary, 6'h00};
    assign stb_poll = summary_bits | {1'b0, rqs_d, 6'h00};

    always_comb begin
        unique case (ssr_query_t'(query_sel))
            SSR_Q_NONE: query_mux = '0;
            SSR_Q_STB: query_mux = {8'h00, stb_query};
            SSR_Q_MASK: query_mux = {8'h00, mask_q};
            SSR_Q_STD: query_mux = {8'h00, std_event_q};
        endcase
    end

    // registered outputs
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            query_data_q <= '0;
            query_valid_q <= 1'b0;
            poll_byte_q <= 8'h00;
            status_summary_byte_q <= 8'h00;
            service_request_q <= 1'b0;
        end else if (clk_en) begin
            query_valid_q <= query_req;
            if (query_req) begin
                query_data_q <= query_mux;
            end
            poll_byte_q <= stb_poll;
            status_summary_byte_q <= stb_query;
            service_request_q <= rqs_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n_q || !clk_en);

    sequence s_rise;
        !enabled_bits[POS_EAV] ##1 enabled_bits[POS_EAV];
    endsequence

    AST_EAV_FOLLOWS: assert property (##1 status_summary_byte_q[POS_EAV] == $past(error_available))
        else $error("eav bit not following error queue");
    AST_MAV_FOLLOWS: assert property (##1 status_summary_byte_q[POS_MAV] == $past(message_available))
        else $error("mav bit not following output queue");
    AST_B1_ZERO: assert property (!status_summary_byte_q[POS_UNUSED] && !poll_byte_q[POS_UNUSED])
        else $error("unused bit set");
    AST_MSS_OR: assert property (##1 status_summary_byte_q[POS_RQS] == $past(|(summary_bits & mask_q & 8'hbd)))
        else $error("master summary wrong");
    AST_RISE_SRQ: assert property (s_rise |=> service_request_q)
        else $error("rising enabled bit gave no request");
    AST_POLL_CLR: assert property (serial_poll_done && !new_request |=> !service_request_q)
        else $error("poll did not clear request");
    AST_POLL_KEEPS_MSS: assert property (serial_poll_done && master_summary && $stable(summary_bits) && $stable(mask_q)
        |=> status_summary_byte_q[POS_RQS])
        else $error("poll cleared master summary");
    AST_MASK_WRITE: assert property (mask_write |=> mask_q == $past(mask_wdata))
        else $error("mask not written");
    AST_MASK_HOLD: assert property ((clear_status || status_preset) && !mask_write |=> $stable(mask_q))
        else $error("mask changed by clear or preset");
    AST_STD_READ_CLR: assert property (std_read && std_event_in == 8'h00 |=> std_event_q == 8'h00)
        else $error("standard register not cleared on read");
    AST_MASK_QUERY: assert property (query_req && ssr_query_t'(query_sel) == SSR_Q_MASK
        |=> query_valid_q && query_data_q == {8'h00, $past(mask_q)})
        else $error("mask query value wrong");

    // ------------------------------------------------------------
    // further checks on the summary positions
    // ------------------------------------------------------------
    // each set summary lands one cycle later at its own position
    AST_MEAS_FOLLOWS: assert property (##1 status_summary_byte_q[POS_MEAS] == $past(meas_summary))
        else $error("measurement summary not at its position");

    AST_QUES_FOLLOWS: assert property (##1 status_summary_byte_q[POS_QUES] == $past(questionable_summary))
        else $error("questionable summary not at its position");

    AST_OPER_FOLLOWS: assert property (##1 status_summary_byte_q[POS_OPER] == $past(operation_summary))
        else $error("operation summary not at its position");

    // the standard summary is never latched a second time here
    AST_STD_FOLLOWS: assert property (##1 status_summary_byte_q[POS_STD] == $past(std_summary))
        else $error("standard summary not following");

    // ------------------------------------------------------------
    // poll byte against query byte
    // ------------------------------------------------------------
    // only B6 may differ between the two views of the byte
    AST_POLL_SAME_BITS: assert property ((poll_byte_q & 8'hbf) == (status_summary_byte_q & 8'hbf))
        else $error("poll byte differs outside the request bit");

    // poll byte B6 carries the request flag, which is also the line
    AST_POLL_B6_RQS: assert property (poll_byte_q[POS_RQS] == service_request_q)
        else $error("poll byte request bit not the request flag");

    AST_STB_QUERY: assert property (query_req && ssr_query_t'(query_sel) == SSR_Q_STB
        |=> query_data_q[7:0] == status_summary_byte_q)
        else $error("status byte query differs from byte");

    // ------------------------------------------------------------
    // query and mask corner cases
    // ------------------------------------------------------------
    // answers never exceed the 8-bit registers here
    AST_UPPER_ZERO: assert property (query_data_q[15:8] == 8'h00)
        else $error("upper answer byte not zero");

    AST_NONE_QUERY: assert property (query_req && ssr_query_t'(query_sel) == SSR_Q_NONE
        |=> query_valid_q && query_data_q == '0)
        else $error("empty query not zero");

    AST_MASK_ZERO: assert property (mask_write && mask_wdata == 8'h00 |=> mask_q == 8'h00)
        else $error("zero write did not clear mask");

    // with no rise and no pending flag the line must stay low
    AST_NO_SPURIOUS: assert property (!new_request && !rqs_q |=> !service_request_q)
        else $error("request without an enabled rise");
endmodule

// file: verification/ssr_poll_ctl.sv
`timescale 1ns/1ps
module ssr_poll_ctl (
    // clock
    input wire logic clk_sys,
    // device side
    input wire logic [7:0] poll_byte,
    output logic serial_poll_done
);
    // ---------------------------------
    // serial poll sequence
    // ---------------------------------
    initial serial_poll_done = 1'b0;
    // called at a falling edge; the standing byte is read, then the
    // completion pulse covers exactly one rising edge
    task automatic poll(output logic [7:0] v);
        v = poll_byte;
        serial_poll_done = 1'b1;
        @(negedge clk_sys);
        serial_poll_done = 1'b0;
    endtask
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ssr_pkg::*;
    // ---------------------------------
    // stimulus and observation
    // ---------------------------------
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] src = 5'h00; // meas, ques, oper, error, message
    logic [7:0] std_ev = 8'h00;
    logic [7:0] std_en = 8'h00;
    logic mw = 1'b0;
    logic [7:0] wd = 8'h00;
    logic qr = 1'b0;
    logic [1:0] qs = 2'b00;
    logic cls = 1'b0;
    logic pre = 1'b0;
    wire logic spd;
    wire logic [REG_W-1:0] qd;
    wire logic qv;
    wire logic [7:0] pb;
    wire logic [7:0] sb;
    wire logic srq;
    logic [7:0] pv;
    int miscompares = 0;
    int n_tests = 0;
    always #2 clk_sys = ~clk_sys;
    // only clk_en is tied; freezing is not exercised
    ssr_status_byte dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .meas_summary(src[0]), .questionable_summary(src[1]), .operation_summary(src[2]),
        .error_available(src[3]), .message_available(src[4]), .std_event_in(std_ev),
        .std_enable(std_en), .mask_write(mw), .mask_wdata(wd), .query_req(qr),
        .query_sel(qs), .clear_status(cls), .status_preset(pre), .serial_poll_done(spd),
        .query_data_q(qd), .query_valid_q(qv), .poll_byte_q(pb),
        .status_summary_byte_q(sb), .service_request_q(srq));
    ssr_poll_ctl ctl (.clk_sys(clk_sys), .poll_byte(pb), .serial_poll_done(spd));
    // ---------------------------------
    // shared tasks
    // ---------------------------------
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(logic [7:0] v);
        mw = 1'b1;
        wd = v;
        tick(1);
        mw = 1'b0;
    endtask
    // answer is registered, so it is looked at one cycle after the request
    task automatic rd(logic [1:0] s, logic [15:0] e);
        qr = 1'b1;
        qs = s;
        tick(1);
        qr = 1'b0;
        chk("qvalid", {15'h0, qv}, 16'h1);
        chk("qdata", qd, e);
    endtask
    // ---------------------------------
    // scenarios
    // ---------------------------------
    task automatic t_reset();
        chk("byte", {8'h0, sb}, 16'h0);
        chk("srq", {15'h0, srq}, 16'h0);
        rd(SSR_Q_MASK, 16'h0);
        rd(SSR_Q_STD, 16'h0);
        rd(SSR_Q_NONE, 16'h0);
        $display("test reset done");
    endtask
    task automatic t_mask();
        logic [7:0] v [3] = '{8'hff, 8'h5a, 8'ha5};
        foreach (v[i]) begin
            wr(v[i]);
            rd(SSR_Q_MASK, {8'h0, v[i]});
        end
        cls = 1'b1;
        pre = 1'b1;
        tick(1);
        cls = 1'b0;
        pre = 1'b0;
        rd(SSR_Q_MASK, 16'h00a5);
        wr(8'h00);
        rd(SSR_Q_MASK, 16'h0);
        $display("test mask done");
    endtask
    // only the unused position enabled: nothing may request
    task automatic t_bits();
        logic [7:0] pos [5] = '{8'h01, 8'h08, 8'h80, 8'h04, 8'h10};
        wr(8'h02);
        for (int i = 0; i < 5; i++) begin
            src = 5'h01 << i;
            tick(1);
            chk("byte", {8'h0, sb}, {8'h0, pos[i]});
            chk("srq", {15'h0, srq}, 16'h0);
        end
        src = 5'h00;
        tick(1);
        chk("byte", {8'h0, sb}, 16'h0);
        $display("test bits done");
    endtask
    task automatic t_srq();
        wr(8'h04);
        src = 5'h08;
        tick(1);
        chk("byte", {8'h0, sb}, 16'h0044);
        chk("srq", {15'h0, srq}, 16'h1);
        ctl.poll(pv);
        chk("poll", {8'h0, pv}, 16'h0044);
        chk("srq", {15'h0, srq}, 16'h0);
        chk("byte", {8'h0, sb}, 16'h0044);
        rd(SSR_Q_STB, 16'h0044);
        ctl.poll(pv);
        chk("poll", {8'h0, pv}, 16'h0004);
        src = 5'h00;
        tick(1);
        chk("byte", {8'h0, sb}, 16'h0);
        src = 5'h08;
        tick(1);
        chk("srq", {15'h0, srq}, 16'h1);
        ctl.poll(pv);
        src = 5'h00;
        $display("test request done");
    endtask
    // event register may add a cycle before the byte, so wait four
    task automatic t_std();
        wr(8'h20);
        std_en = 8'h81;
        std_ev = 8'h80;
        tick(1);
        std_ev = 8'h00;
        tick(4);
        chk("byte", {8'h0, sb}, 16'h0060);
        rd(SSR_Q_STD, 16'h0080);
        tick(2);
        chk("byte", {8'h0, sb}, 16'h0);
        ctl.poll(pv);
        $display("test standard done");
    endtask
    // ---------------------------------
    // run control
    // ---------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        tick(2);
        reset_n = 1'b1;
        tick(3);
        t_reset();
        t_mask();
        t_bits();
        t_srq();
        t_std();
        test_done();
    end
    // whole run is under fifty cycles; cut off far beyond that
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule
